//--- src/fcc_crc_check.sv
`timescale 1ns/1ps
`include "fcc_consts.svh"
// Summary of operation
// - The engine computes a 64-bit CRC with the degree-64 ECMA generator over the chosen array bytes.
// - Each byte enters least significant bit first and the CRC starts from all zeros.
// - The option byte chooses the whole array or the start and stop addresses of the sequence.
// - The result is compared with the expected code and pass or fail shows on flag status bit 4.
// - The readback buffer takes the computed code only on a fail and stays zero on a pass.
// - Command 96h reads the readback buffer out least significant byte first.
// - The readback buffer is cleared to zero when each check starts.
// - The readback buffer is cleared on power-up and on hardware or software reset.
// - A buffer read starts at the first location and gives 00h for every location past 64.
// - The third byte FFh picks the whole device and FEh picks an address range.
// - Chip select rising after the last byte confirms the sequence and starts the computation.
module fcc_crc_check #(
   parameter logic [31:0] ARRAY_LAST = `FCC_ARRAY_LAST
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_soft_rst,
   // serial link
   input  wire logic        i_spi_clk,
   input  wire logic        i_spi_cs_n,
   input  wire logic        i_spi_mosi,
   output logic             o_spi_miso,
   output logic             o_spi_miso_oe,
   // array read port
   output logic             o_mem_rd_req,
   output logic      [31:0] o_mem_addr,
   input  wire logic        i_mem_rd_valid,
   input  wire fcc_pkg::fcc_byte_t i_mem_rd_data,
   // status
   output logic             o_flag_crc_fail,
   output logic             o_crc_busy
);
   import fcc_pkg::*;
   // ==========================================================
   // link synchronisers
   logic sclk_s1_r, sclk_s2_r, sclk_s3_r, cs_s1_r, cs_s2_r, cs_s3_r, mosi_s1_r, mosi_s2_r;
   logic sclk_rise, sclk_fall, cs_low, cs_rise, byte_done;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
         {cs_s1_r, cs_s2_r, cs_s3_r}       <= 3'h7;
         {mosi_s1_r, mosi_s2_r}            <= 2'h0;
      end else begin
         {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {i_spi_clk, sclk_s1_r, sclk_s2_r};
         {cs_s1_r, cs_s2_r, cs_s3_r}       <= {i_spi_cs_n, cs_s1_r, cs_s2_r};
         {mosi_s1_r, mosi_s2_r}            <= {i_spi_mosi, mosi_s1_r};
      end
   end
   // ==========================================================
   // sequence receiver and readback transmitter
   logic [2:0]  bit_cnt_r, bit_cnt_nxt;
   fcc_byte_t   shift_r, shift_nxt, rx_byte;
   logic [4:0]  byte_idx_r, byte_idx_nxt;
   fcc_byte_t   cmd_r, cmd_nxt, opt_r, opt_nxt, tx_r, tx_nxt, buf_byte;
   logic        sub_ok_r, sub_ok_nxt, go_r, go_nxt, range_r, range_nxt;
   logic [63:0] exp_r, exp_nxt;
   logic [31:0] start_r, start_nxt, stop_r, stop_nxt;
   logic [6:0]  rd_idx_r, rd_idx_nxt;
   logic        miso_r, miso_nxt, miso_oe_r, miso_oe_nxt;
   logic [63:0] buffer_r;
   assign sclk_rise = sclk_s2_r & ~sclk_s3_r;
   assign sclk_fall = ~sclk_s2_r & sclk_s3_r;
   assign cs_low    = ~cs_s2_r;
   assign cs_rise   = cs_s2_r & ~cs_s3_r;
   assign byte_done = cs_low & sclk_rise & (bit_cnt_r == `FCC_BITS_LAST);
   assign rx_byte   = {shift_r[6:0], mosi_s2_r};
   // locations past the code itself read as zero, so past 64 stays zero too
   assign buf_byte  = (rd_idx_r < `FCC_BUF_BYTES) ? buffer_r[{rd_idx_r[2:0], 3'b000} +: 8] : 8'h00;
   always_comb begin
      bit_cnt_nxt  = bit_cnt_r;
      shift_nxt    = shift_r;
      byte_idx_nxt = byte_idx_r;
      cmd_nxt      = cmd_r;
      opt_nxt      = opt_r;
      sub_ok_nxt   = sub_ok_r;
      exp_nxt      = exp_r;
      start_nxt    = start_r;
      stop_nxt     = stop_r;
      tx_nxt       = tx_r;
      rd_idx_nxt   = rd_idx_r;
      miso_nxt     = miso_r;
      miso_oe_nxt  = miso_oe_r;
      range_nxt    = range_r;
      go_nxt       = 1'b0;
      if (cs_rise) begin
         go_nxt = (cmd_r == `FCC_CMD_CRC) && sub_ok_r &&
                  (((opt_r == `FCC_OPT_WHOLE) && (byte_idx_r >= `FCC_LEN_WHOLE)) ||
                   ((opt_r == `FCC_OPT_RANGE) && (byte_idx_r >= `FCC_LEN_RANGE)));
         range_nxt    = (opt_r == `FCC_OPT_RANGE);
         bit_cnt_nxt  = 3'h0;
         byte_idx_nxt = 5'h00;
         cmd_nxt      = 8'h00;
         opt_nxt      = 8'h00;
         sub_ok_nxt   = 1'b0;
         rd_idx_nxt   = 7'h00;
         miso_nxt     = 1'b0;
         miso_oe_nxt  = 1'b0;
      end else if (cs_low) begin
         miso_oe_nxt = (cmd_r == `FCC_CMD_READBACK) && (byte_idx_r != 5'h00);
         if (sclk_rise) begin
            shift_nxt   = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
         end
         if (byte_done) begin
            if (byte_idx_r != `FCC_IDX_MAX) begin
               byte_idx_nxt = byte_idx_r + 5'h01;
            end
            if (byte_idx_r == `FCC_POS_CMD) begin
               cmd_nxt = rx_byte;
            end
            if (byte_idx_r == `FCC_POS_SUB) begin
               sub_ok_nxt = (rx_byte == `FCC_SUB_CRC);
            end
            if (byte_idx_r == `FCC_POS_OPT) begin
               opt_nxt = rx_byte;
            end
            if ((byte_idx_r >= `FCC_POS_EXP) && (byte_idx_r < `FCC_POS_START)) begin
               exp_nxt = {rx_byte, exp_r[63:8]};
            end
            if ((byte_idx_r >= `FCC_POS_START) && (byte_idx_r < `FCC_POS_STOP)) begin
               start_nxt = {rx_byte, start_r[31:8]};
            end
            if ((byte_idx_r >= `FCC_POS_STOP) && (byte_idx_r < `FCC_LEN_RANGE)) begin
               stop_nxt = {rx_byte, stop_r[31:8]};
            end
            if (((byte_idx_r == `FCC_POS_CMD) && (rx_byte == `FCC_CMD_READBACK)) || (cmd_r == `FCC_CMD_READBACK)) begin
               tx_nxt = buf_byte;
               if (rd_idx_r <= `FCC_BUF_LOCS) begin
                  rd_idx_nxt = rd_idx_r + 7'h01;
               end
            end
         end
         if (sclk_fall && (cmd_r == `FCC_CMD_READBACK) && (byte_idx_r != 5'h00)) begin
            miso_nxt = tx_r[7];
            tx_nxt   = {tx_r[6:0], 1'b0};
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         bit_cnt_r  <= 3'h0;
         shift_r    <= 8'h00;
         byte_idx_r <= 5'h00;
         cmd_r      <= 8'h00;
         opt_r      <= 8'h00;
         sub_ok_r   <= 1'b0;
         exp_r      <= 64'h0000000000000000;
         start_r    <= 32'h00000000;
         stop_r     <= 32'h00000000;
         tx_r       <= 8'h00;
         rd_idx_r   <= 7'h00;
         miso_r     <= 1'b0;
         miso_oe_r  <= 1'b0;
         range_r    <= 1'b0;
         go_r       <= 1'b0;
      end else begin
         bit_cnt_r  <= bit_cnt_nxt;
         shift_r    <= shift_nxt;
         byte_idx_r <= byte_idx_nxt;
         cmd_r      <= cmd_nxt;
         opt_r      <= opt_nxt;
         sub_ok_r   <= sub_ok_nxt;
         exp_r      <= exp_nxt;
         start_r    <= start_nxt;
         stop_r     <= stop_nxt;
         tx_r       <= tx_nxt;
         rd_idx_r   <= rd_idx_nxt;
         miso_r     <= miso_nxt;
         miso_oe_r  <= miso_oe_nxt;
         range_r    <= range_nxt;
         go_r       <= go_nxt;
      end
   end
   // ==========================================================
   // check sequencer, one array read in flight at a time
   fcc_op_e     state_r, state_nxt;
   logic [31:0] addr_r, addr_nxt, last_r, last_nxt, mem_addr_r, mem_addr_nxt;
   logic [63:0] exp_op_r, exp_op_nxt, buffer_nxt;
   logic        issue_done_r, issue_done_nxt, wait_r, wait_nxt;
   logic        req_r, req_nxt, fail_r, fail_nxt, clr_r, clr_nxt;
   logic        op_rst, fifo_in_ready, fifo_out_valid, crc_ready;
   fcc_byte_t   fifo_out_data;
   logic [63:0] crc_val;
   // software reset aborts the check and empties the data path
   assign op_rst = i_sys_rst | i_soft_rst;
   always_comb begin
      state_nxt      = state_r;
      addr_nxt       = addr_r;
      last_nxt       = last_r;
      mem_addr_nxt   = mem_addr_r;
      exp_op_nxt     = exp_op_r;
      buffer_nxt     = buffer_r;
      issue_done_nxt = issue_done_r;
      wait_nxt       = wait_r;
      fail_nxt       = fail_r;
      req_nxt        = 1'b0;
      clr_nxt        = 1'b0;
      case (state_r)
         FCC_IDLE: begin
            if (go_r) begin
               buffer_nxt     = `FCC_BUF_RESET;
               fail_nxt       = 1'b0;
               clr_nxt        = 1'b1;
               exp_op_nxt     = exp_r;
               addr_nxt       = range_r ? start_r : 32'h00000000;
               last_nxt       = range_r ? stop_r : ARRAY_LAST;
               issue_done_nxt = range_r && (stop_r < start_r);
               wait_nxt       = 1'b0;
               state_nxt      = FCC_RUN;
            end
         end
         FCC_RUN: begin
            if (i_mem_rd_valid) begin
               wait_nxt = 1'b0;
            end
            if (!issue_done_r && !wait_r && fifo_in_ready) begin
               req_nxt  = 1'b1;
               mem_addr_nxt = addr_r;
               wait_nxt = 1'b1;
               if (addr_r == last_r) begin
                  issue_done_nxt = 1'b1;
               end else begin
                  addr_nxt = addr_r + 32'h00000001;
               end
            end
            if (issue_done_r && !wait_r && !fifo_out_valid && crc_ready) begin
               state_nxt = FCC_CMP;
            end
         end
         FCC_CMP: begin
            if (crc_val != exp_op_r) begin
               fail_nxt   = 1'b1;
               buffer_nxt = crc_val;
            end
            state_nxt = FCC_IDLE;
         end
         default: begin
            state_nxt = FCC_IDLE;
         end
      endcase
   end
   always_ff @(posedge i_clk) begin
      if (op_rst) begin
         state_r      <= FCC_IDLE;
         addr_r       <= 32'h00000000;
         mem_addr_r   <= 32'h00000000;
         last_r       <= 32'h00000000;
         exp_op_r     <= 64'h0000000000000000;
         buffer_r     <= `FCC_BUF_RESET;
         issue_done_r <= 1'b0;
         wait_r       <= 1'b0;
         req_r        <= 1'b0;
         fail_r       <= 1'b0;
         clr_r        <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         addr_r       <= addr_nxt;
         last_r       <= last_nxt;
         exp_op_r     <= exp_op_nxt;
         buffer_r     <= buffer_nxt;
         issue_done_r <= issue_done_nxt;
         wait_r       <= wait_nxt;
         req_r        <= req_nxt;
         fail_r       <= fail_nxt;
         clr_r        <= clr_nxt;
         mem_addr_r   <= mem_addr_nxt;
      end
   end

   // ==========================================================
   // data path
   fcc_fifo #(.WIDTH(`FCC_FIFO_WIDTH), .DEPTH(`FCC_FIFO_DEPTH)) u_fifo (
      .i_clk       (i_clk),
      .i_sys_rst   (op_rst),
      .i_in_valid  (i_mem_rd_valid & (state_r == FCC_RUN)),
      .i_in_data   (i_mem_rd_data),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (fifo_out_valid),
      .o_out_data  (fifo_out_data),
      .i_out_ready (crc_ready)
   );
   fcc_crc64 u_crc (
      .i_clk     (i_clk),
      .i_sys_rst (op_rst),
      .i_clear   (clr_r),
      .i_valid   (fifo_out_valid),
      .i_byte    (fifo_out_data),
      .o_ready   (crc_ready),
      .o_crc     (crc_val)
   );
   assign o_spi_miso      = miso_r;
   assign o_spi_miso_oe   = miso_oe_r;
   assign o_mem_rd_req    = req_r;
   assign o_mem_addr      = mem_addr_r;
   assign o_flag_crc_fail = fail_r;
   assign o_crc_busy      = (state_r != FCC_IDLE);
   // ==========================================================
   // checks
   chk_buf_start_zero: assert property (@(posedge i_clk) disable iff (op_rst)
      (state_r == FCC_IDLE && go_r) |=> (buffer_r == 64'h0000000000000000) && !fail_r)
      else $error("buffer not cleared at check start");
   chk_pass_keeps_zero: assert property (@(posedge i_clk) disable iff (op_rst)
      (state_r == FCC_CMP && crc_val == exp_op_r) |=> (buffer_r == 64'h0000000000000000) && !o_flag_crc_fail)
      else $error("pass altered buffer or flag");
   chk_fail_stores_code: assert property (@(posedge i_clk) disable iff (op_rst)
      (state_r == FCC_CMP && crc_val != exp_op_r) |=> (buffer_r == $past(crc_val)) && o_flag_crc_fail)
      else $error("fail not reported or stored");
   chk_soft_rst_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_soft_rst |=> (buffer_r == 64'h0000000000000000) && (state_r == FCC_IDLE))
      else $error("soft reset left buffer set");
   chk_short_seq_drop: assert property (@(posedge i_clk) disable iff (op_rst)
      (cs_rise && state_r == FCC_IDLE && cmd_r == `FCC_CMD_CRC && byte_idx_r < `FCC_LEN_WHOLE)
      |=> ##1 (state_r == FCC_IDLE))
      else $error("short sequence started a check");
   chk_go_after_cs: assert property (@(posedge i_clk) disable iff (op_rst)
      go_r |-> $past(cs_rise) && $past(cmd_r) == `FCC_CMD_CRC)
      else $error("check started without chip select rise");
   chk_range_start_addr: assert property (@(posedge i_clk) disable iff (op_rst)
      (state_r == FCC_IDLE && go_r && range_r) |=> (addr_r == $past(start_r)) && (last_r == $past(stop_r)))
      else $error("range addresses not taken");
   chk_whole_last_addr: assert property (@(posedge i_clk) disable iff (op_rst)
      (state_r == FCC_IDLE && go_r && !range_r) |=> (addr_r == 32'h00000000) && (last_r == ARRAY_LAST))
      else $error("whole device bounds wrong");
   chk_read_lsb_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (byte_done && byte_idx_r == 5'h00 && rx_byte == `FCC_CMD_READBACK) |=> (tx_r == buffer_r[7:0]))
      else $error("readback not lowest byte first");
   chk_read_zero_past: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (byte_done && cmd_r == `FCC_CMD_READBACK && rd_idx_r >= `FCC_BUF_BYTES) |=> (tx_r == 8'h00))
      else $error("readback past code not zero");
endmodule : fcc_crc_check

//--- src/fcc_consts.svh
`ifndef FCC_CONSTS_SVH
`define FCC_CONSTS_SVH

// ==========================================================
// command codes and option bytes
`define FCC_CMD_CRC        8'h9B
`define FCC_SUB_CRC        8'h27
`define FCC_OPT_WHOLE      8'hFF
`define FCC_OPT_RANGE      8'hFE
`define FCC_CMD_READBACK   8'h96

// ==========================================================
// sequence layout, zero-based byte positions
`define FCC_POS_CMD        5'h00
`define FCC_POS_SUB        5'h01
`define FCC_POS_OPT        5'h02
`define FCC_POS_EXP        5'h03
`define FCC_POS_START      5'h0B
`define FCC_POS_STOP       5'h0F
`define FCC_LEN_WHOLE      5'h0B
`define FCC_LEN_RANGE      5'h13
`define FCC_IDX_MAX        5'h1F

// ==========================================================
// crc engine and readback buffer
`define FCC_POLY_REFL      64'hC96C5795D7870F42
`define FCC_CRC_INIT       64'h0000000000000000
`define FCC_BUF_RESET      64'h0000000000000000
`define FCC_BUF_BYTES      7'h08
`define FCC_BUF_LOCS       7'h40
`define FCC_BITS_LAST      3'h7

// ==========================================================
// array size and data path
`define FCC_ARRAY_LAST     32'h03FFFFFF
`define FCC_FIFO_WIDTH     8
`define FCC_FIFO_DEPTH     4

`endif

//--- src/fcc_pkg.sv
package fcc_pkg;
   // ==========================================================
   // types
   typedef logic [7:0] fcc_byte_t;

   typedef enum logic [2:0] {
      FCC_IDLE = 3'b001,
      FCC_RUN  = 3'b010,
      FCC_CMP  = 3'b100
   } fcc_op_e;
endpackage : fcc_pkg

//--- src/fcc_fifo.sv
`timescale 1ns/1ps
module fcc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // drain side
   output logic                  o_out_valid,
   output logic      [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      wr_ptr_nxt;
   logic [AW:0]      rd_ptr_r;
   logic [AW:0]      rd_ptr_nxt;
   logic             push;
   logic             pop;

   // ==========================================================
   // pointers, extra bit tells full from empty
   assign o_in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
   assign o_out_valid = wr_ptr_r != rd_ptr_r;
   assign o_out_data  = mem[rd_ptr_r[AW-1:0]];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      if (push) begin
         wr_ptr_nxt = wr_ptr_r + (AW+1)'(1);
      end
      if (pop) begin
         rd_ptr_nxt = rd_ptr_r + (AW+1)'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= i_in_data;
      end
   end
endmodule : fcc_fifo

//--- src/fcc_crc64.sv
`timescale 1ns/1ps
`include "fcc_consts.svh"
module fcc_crc64 (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // control
   input  wire logic             i_clear,
   // byte stream
   input  wire logic             i_valid,
   input  wire fcc_pkg::fcc_byte_t i_byte,
   output logic                  o_ready,
   // result
   output logic          [63:0]  o_crc
);
   import fcc_pkg::*;

   logic [63:0] crc_r;
   logic [63:0] crc_nxt;
   fcc_byte_t   sh_r;
   fcc_byte_t   sh_nxt;
   logic [2:0]  cnt_r;
   logic [2:0]  cnt_nxt;
   logic        busy_r;
   logic        busy_nxt;
   logic        fb;

   // ==========================================================
   // bit-serial engine, one bit per cycle to save area
   assign o_ready = ~busy_r;
   assign o_crc   = crc_r;
   assign fb      = crc_r[0] ^ sh_r[0];

   always_comb begin
      crc_nxt  = crc_r;
      sh_nxt   = sh_r;
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      if (i_clear) begin
         crc_nxt  = `FCC_CRC_INIT;
         busy_nxt = 1'b0;
      end else if (busy_r) begin
         crc_nxt = (crc_r >> 1) ^ (fb ? `FCC_POLY_REFL : 64'h0000000000000000);
         sh_nxt  = {1'b0, sh_r[7:1]};
         cnt_nxt = cnt_r + 3'h1;
         if (cnt_r == `FCC_BITS_LAST) begin
            busy_nxt = 1'b0;
         end
      end else if (i_valid) begin
         sh_nxt   = i_byte;
         cnt_nxt  = 3'h0;
         busy_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         crc_r  <= `FCC_CRC_INIT;
         sh_r   <= 8'h00;
         cnt_r  <= 3'h0;
         busy_r <= 1'b0;
      end else begin
         crc_r  <= crc_nxt;
         sh_r   <= sh_nxt;
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   // ==========================================================
   // checks
   chk_crc_clear_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_clear |=> (o_crc == 64'h0000000000000000))
      else $error("crc not zero after clear");

   chk_crc_byte_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_valid && o_ready && !i_clear) |=> (!o_ready [*8]) ##1 o_ready)
      else $error("crc byte not eight cycles");
endmodule : fcc_crc64

//--- testbench/fcc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host controller model, mode 0, 80 ns serial clock
module fcc_host_model (
   // serial link
   output logic      o_spi_clk,
   output logic      o_spi_cs_n,
   output logic      o_spi_mosi,
   input  wire logic i_spi_miso
);
   // clock stands low between frames
   initial begin
      o_spi_clk  = 1'b0;
      o_spi_cs_n = 1'b1;
      o_spi_mosi = 1'b0;
   end
   task automatic open_frame();
      o_spi_cs_n = 1'b0;
      #40;
   endtask : open_frame
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_spi_mosi = b[i];
         #40;
         o_spi_clk = 1'b1;
         #40;
         o_spi_clk = 1'b0;
      end
   endtask : send
   // sample mid-high: the device moves miso only after the next fall
   task automatic recv(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         #40;
         o_spi_clk = 1'b1;
         #20;
         b[i] = i_spi_miso;
         #20;
         o_spi_clk = 1'b0;
      end
   endtask : recv
   task automatic close_frame();
      #40;
      o_spi_cs_n = 1'b1;
      o_spi_mosi = ~o_spi_mosi;
      #240;
   endtask : close_frame
endmodule : fcc_host_model

//--- testbench/fcc_crc_check_bench.sv
`timescale 1ns/1ps
`include "fcc_consts.svh"
module fcc_crc_check_bench;
   import fcc_pkg::*;
   localparam logic [31:0] LAST = 32'h0000003F;
   logic clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, valid = 1'b0;
   logic sclk, cs_n, mosi, miso, miso_oe, miso_w, req, fail, busy;
   logic [31:0] addr;
   fcc_byte_t   rdata = 8'h00;
   int          bad_count = 0;
   int          n_compared = 0;
   always #5 clk = ~clk;
   // pull-up on the shared data-out line
   assign miso_w = miso_oe ? miso : 1'b1;
   fcc_crc_check #(.ARRAY_LAST(LAST)) u_dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_soft_rst(soft_rst),
      .i_spi_clk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
      .o_mem_rd_req(req), .o_mem_addr(addr), .i_mem_rd_valid(valid), .i_mem_rd_data(rdata),
      .o_flag_crc_fail(fail), .o_crc_busy(busy));
   fcc_host_model u_host (.o_spi_clk(sclk), .o_spi_cs_n(cs_n), .o_spi_mosi(mosi), .i_spi_miso(miso_w));
   function automatic fcc_byte_t mem_byte(input logic [31:0] a);
      return (a[7:0] * 8'h1D) ^ 8'h5A;
   endfunction : mem_byte
   // ==========================================================
   // array model, one cycle latency
   always @(posedge clk) begin : mem_model
      logic        take;
      logic [31:0] a;
      take = req;
      a = addr;
      #1;
      valid = take;
      rdata = mem_byte(a);
   end
   function automatic logic [63:0] crc_ref(input logic [31:0] s, input logic [31:0] p);
      logic [63:0] c;
      fcc_byte_t   d;
      c = `FCC_CRC_INIT;
      for (logic [32:0] a = {1'b0, s}; a <= {1'b0, p}; a++) begin
         d = mem_byte(a[31:0]);
         for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? `FCC_POLY_REFL : 64'h0);
         end
      end
      return c;
   endfunction : crc_ref
   // ==========================================================
   // compare and closing
   task automatic results();
      if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   task automatic run_seq(input logic [7:0] opt, input logic [63:0] e, input logic [31:0] s, p, input int n);
      logic [7:0]  seq [19];
      logic [63:0] sp;
      sp = {p, s};
      seq[0] = `FCC_CMD_CRC;
      seq[1] = `FCC_SUB_CRC;
      seq[2] = opt;
      for (int i = 0; i < 8; i++) begin
         seq[3+i] = e[8*i+:8];
         seq[11+i] = sp[8*i+:8];
      end
      @(posedge clk);
      #1;
      u_host.open_frame();
      for (int i = 0; i < n; i++) u_host.send(seq[i]);
      u_host.close_frame();
      chk_bit("busy after frame", n >= ((opt == `FCC_OPT_WHOLE) ? 11 : 19), busy);
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      if (busy !== 1'b0) begin
         chk_bit("busy timeout", 1'b0, busy);
         results();
      end
   endtask : run_seq
   task automatic readback(output logic [79:0] v);
      @(posedge clk);
      #1;
      u_host.open_frame();
      u_host.send(`FCC_CMD_READBACK);
      for (int i = 0; i < 10; i++) u_host.recv(v[8*i+:8]);
      u_host.close_frame();
   endtask : readback
   // ==========================================================
   // scenarios
   task automatic s_whole_fail();
      logic [63:0] c;
      logic [79:0] rb;
      c = crc_ref(0, LAST);
      run_seq(`FCC_OPT_WHOLE, ~c, 0, 0, 11);
      chk_bit("fail flag whole", 1'b1, fail);
      readback(rb);
      chk_val("readback code", c, rb[63:0]);
      chk_val("readback past end", 64'h0, {48'h0, rb[79:64]});
   endtask : s_whole_fail
   task automatic s_range_pass();
      logic [79:0] rb;
      run_seq(`FCC_OPT_RANGE, crc_ref(5, 20), 5, 20, 19);
      chk_bit("fail flag range", 1'b0, fail);
      readback(rb);
      chk_val("readback after pass", 64'h0, rb[63:0]);
   endtask : s_range_pass
   task automatic s_soft_reset();
      logic [79:0] rb;
      run_seq(`FCC_OPT_RANGE, crc_ref(8'h30, LAST) ^ 64'h1, 8'h30, LAST, 19);
      chk_bit("fail flag range", 1'b1, fail);
      @(posedge clk);
      #1 soft_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 soft_rst = 1'b0;
      chk_bit("fail flag after soft reset", 1'b0, fail);
      readback(rb);
      chk_val("readback after soft reset", 64'h0, rb[63:0]);
   endtask : s_soft_reset
   task automatic s_short_frame();
      run_seq(`FCC_OPT_RANGE, 64'h1, 0, LAST, 18);
      run_seq(`FCC_OPT_WHOLE, 64'h1, 0, 0, 10);
      chk_bit("fail flag untouched", 1'b0, fail);
   endtask : s_short_frame
   initial begin
      repeat (10) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (5) @(posedge clk);
      s_whole_fail();
      s_range_pass();
      s_soft_reset();
      s_short_frame();
      results();
   end
endmodule : fcc_crc_check_bench
